// *** design/tmo_pkg.sv ***
package tmo_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
  localparam logic [7:0] ADDR_TIMER_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_COMPARE_ONE = 8'h0C;
  localparam logic [7:0] ADDR_COMPARE_TWO = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE_ONE = 8'h14;
  localparam logic [7:0] ADDR_CAPTURE_TWO = 8'h18;
  localparam logic [7:0] ADDR_COUNTER = 8'h1C;
  // control_one fields
  localparam int C1_AFTER_LVL = 0;
  localparam int C1_DURING_LVL = 1;
  localparam int C1_FORCE_ONE = 2;
  localparam int C1_FORCE_TWO = 3;
  localparam int C1_EDGE_ONE = 4;
  localparam int C1_CMP_IE = 5;
  localparam int C1_CAP_IE = 6;
  // control_two fields
  localparam int C2_PIN_EN_ONE = 0;
  localparam int C2_PIN_EN_TWO = 1;
  localparam int C2_CLK_SEL = 2;
  localparam int C2_SINGLE_PULSE = 4;
  localparam int C2_PWM = 5;
  localparam int C2_EDGE_TWO = 6;
  // timer_flags fields
  localparam int F_CMP_ONE = 0;
  localparam int F_CMP_TWO = 1;
  localparam int F_CAP_ONE = 2;
  localparam int F_CAP_TWO = 3;
  // Reset and reload values
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNTER_START = 8'hFC;
  localparam logic [7:0] TRIGGER_CAPTURE = 8'hFD;
  // Timer clock selections and prescale factors
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam int PRESC_DIV2 = 2;
  localparam int PRESC_DIV4 = 4;
  localparam int PRESC_DIV8 = 8;
  localparam int PRESC_SLOW = 8000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tmo_pkg

// *** design/tmo_timer.sv ***
`timescale 1ns/1ps
// How it works
// - Match sets flag, drives level if enabled
// - Two 8-bit compare registers, software only
// - Reset clears both compare registers
// - Compare pin latches low during reset
// - Interrupt needs compare enable, mask clear
// - Status read then compare access clears
// - Disabled pin gets no level, flag still
// - Match at value, or value+1 when slower
// - Force copies level, no flag, no interrupt
// - Force ignored in pulse or modulation mode
// - Control two bit selects single pulse
// - Trigger reloads counter, starts pulse, captures
// - Trigger capture flag may request interrupt
// - Compare one match ends the pulse
// - Pulse mode never sets compare flag one
// - Modulation bit overrides single pulse bit
// - Capture one idle, capture two still works
// - Compare two only flags, pin two static
// - Equal levels give a constant pin
// - Status read then capture access clears
// - Free-running counter, write restarts it
module tmo_timer
  import tmo_pkg::*;
#(
  parameter int SLOW_DIV = PRESC_SLOW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_irq_mask,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  output logic compare_output_pin_one,
  output logic compare_output_pin_one_oe,
  output logic compare_output_pin_two,
  output logic compare_output_pin_two_oe,
  output logic timer_irq
);

  typedef struct packed {
    logic [6:0] control_one;
    logic [6:0] control_two;
    logic [7:0] compare_value_one;
    logic [7:0] compare_value_two;
    logic [7:0] capture_value_one;
    logic [7:0] capture_value_two;
    logic [7:0] count;
    logic [3:0] flags;
    logic [3:0] armed;
    logic [1:0] pin;
    logic [1:0] pin_oe;
    logic irq;
    logic [12:0] presc;
    logic tick;
    logic tick_d;
    logic [2:0] sync_one;
    logic [2:0] sync_two;
    logic [1:0] level;
    logic awready;
    logic wready;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } tmo_state_t;

  tmo_state_t r_reg;
  tmo_state_t r_next;

  // Outputs straight from state
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rdata = {24'h000000, r_reg.rdata};
  assign compare_output_pin_one = r_reg.pin[0];
  assign compare_output_pin_two = r_reg.pin[1];
  assign compare_output_pin_one_oe = r_reg.pin_oe[0];
  assign compare_output_pin_two_oe = r_reg.pin_oe[1];
  assign timer_irq = r_reg.irq;

  // Next-state logic for the whole block
  always_comb begin
    logic [12:0] limit;
    logic [1:0] clk_sel;
    logic pwm_mode;
    logic pulse_mode;
    logic [7:0] target_one;
    logic [7:0] target_two;
    logic match_one;
    logic match_two;
    logic agree_one;
    logic agree_two;
    logic edge_one;
    logic edge_two;
    logic do_write;
    logic do_read;
    logic [7:0] rd_addr;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    logic count_write;
    logic [3:0] clr;
    limit = 13'(SLOW_DIV - 1);
    clk_sel = r_reg.control_two[C2_CLK_SEL +: 2];
    pwm_mode = r_reg.control_two[C2_PWM];
    pulse_mode = r_reg.control_two[C2_SINGLE_PULSE] & ~pwm_mode;
    target_one = r_reg.compare_value_one;
    target_two = r_reg.compare_value_two;
    match_one = 1'b0;
    match_two = 1'b0;
    // A pin change counts once stages two and three agree
    agree_one = r_reg.sync_one[1] == r_reg.sync_one[2];
    agree_two = r_reg.sync_two[1] == r_reg.sync_two[2];
    edge_one = agree_one & (r_reg.sync_one[2] != r_reg.level[0]) &
               (r_reg.sync_one[2] == r_reg.control_one[C1_EDGE_ONE]);
    edge_two = agree_two & (r_reg.sync_two[2] != r_reg.level[1]) &
               (r_reg.sync_two[2] == r_reg.control_two[C2_EDGE_TWO]);
    do_write = ~r_reg.awready & ~r_reg.wready & ~r_reg.bvalid;
    do_read = s_axi_arvalid & ~r_reg.rvalid & ~r_reg.arready;
    rd_addr = s_axi_araddr[7:0];
    rd_val = 8'h00;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    count_write = 1'b0;
    clr = 4'h0;
    r_next = r_reg;

    // Prescaler: one tick per timer clock period; the slow clock is the default
    if (clk_sel == CLK_DIV2) begin
      limit = 13'(PRESC_DIV2 - 1);
    end else if (clk_sel == CLK_DIV4) begin
      limit = 13'(PRESC_DIV4 - 1);
    end else if (clk_sel == CLK_DIV8) begin
      limit = 13'(PRESC_DIV8 - 1);
    end
    r_next.tick = 1'b0;
    if (r_reg.presc >= limit) begin
      r_next.presc = 13'h0000;
      r_next.tick = 1'b1;
    end else begin
      r_next.presc = r_reg.presc + 13'h0001;
    end
    r_next.tick_d = r_reg.tick;

    // Capture pins pass three flops before the edge logic sees them
    r_next.sync_one = {r_reg.sync_one[1:0], capture_input_one};
    r_next.sync_two = {r_reg.sync_two[1:0], capture_input_two};
    if (agree_one) begin
      r_next.level[0] = r_reg.sync_one[2];
    end
    if (agree_two) begin
      r_next.level[1] = r_reg.sync_two[2];
    end

    // Compare once, the cycle after each tick; slower clocks lag one count
    if (clk_sel != CLK_DIV2) begin
      target_one = r_reg.compare_value_one + 8'h01;
      target_two = r_reg.compare_value_two + 8'h01;
    end
    match_one = r_reg.tick_d & (r_reg.count == target_one);
    match_two = r_reg.tick_d & (r_reg.count == target_two);

    // AXI write: address and data taken in either order
    r_next.arready = 1'b0;
    if (s_axi_awvalid & r_reg.awready) begin
      r_next.awready = 1'b0;
      r_next.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid & r_reg.wready) begin
      r_next.wready = 1'b0;
      r_next.w_data = s_axi_wdata[7:0];
      r_next.w_lane = s_axi_wstrb[0];
    end
    if (r_reg.bvalid & s_axi_bready) begin
      r_next.bvalid = 1'b0;
      r_next.awready = 1'b1; // Ready again only once the response has gone
      r_next.wready = 1'b1;
    end

    // AXI read: arready pulses for one cycle when a read is taken
    if (r_reg.rvalid & s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end

    // Read decode and its side effects
    if (do_read) begin
      if (rd_addr == ADDR_CONTROL_ONE) begin
        rd_val = {1'b0, r_reg.control_one};
      end else if (rd_addr == ADDR_CONTROL_TWO) begin
        rd_val = {1'b0, r_reg.control_two};
      end else if (rd_addr == ADDR_TIMER_FLAGS) begin
        rd_val = {4'h0, r_reg.flags};
        r_next.armed = r_reg.flags;
      end else if (rd_addr == ADDR_COMPARE_ONE) begin
        rd_val = r_reg.compare_value_one;
        clr[F_CMP_ONE] = r_reg.armed[F_CMP_ONE];
      end else if (rd_addr == ADDR_COMPARE_TWO) begin
        rd_val = r_reg.compare_value_two;
        clr[F_CMP_TWO] = r_reg.armed[F_CMP_TWO];
      end else if (rd_addr == ADDR_CAPTURE_ONE) begin
        rd_val = r_reg.capture_value_one;
        clr[F_CAP_ONE] = r_reg.armed[F_CAP_ONE];
      end else if (rd_addr == ADDR_CAPTURE_TWO) begin
        rd_val = r_reg.capture_value_two;
        clr[F_CAP_TWO] = r_reg.armed[F_CAP_TWO];
      end else if (rd_addr == ADDR_COUNTER) begin
        rd_val = r_reg.count;
      end else begin
        rd_ok = 1'b0;
      end
      r_next.arready = 1'b1;
      r_next.rvalid = 1'b1;
      r_next.rdata = rd_val;
      r_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Write decode; a cleared byte lane still counts as an access
    if (do_write) begin
      r_next.bvalid = 1'b1;
      if (r_reg.aw_addr == ADDR_CONTROL_ONE) begin
        if (r_reg.w_lane) begin
          r_next.control_one = r_reg.w_data[6:0];
          r_next.control_one[C1_FORCE_ONE] = 1'b0; // Force bits act once
          r_next.control_one[C1_FORCE_TWO] = 1'b0;
        end
      end else if (r_reg.aw_addr == ADDR_CONTROL_TWO) begin
        if (r_reg.w_lane) begin
          r_next.control_two = r_reg.w_data[6:0];
        end
      end else if (r_reg.aw_addr == ADDR_COMPARE_ONE) begin
        if (r_reg.w_lane) begin
          r_next.compare_value_one = r_reg.w_data;
        end
        clr[F_CMP_ONE] = r_reg.armed[F_CMP_ONE];
      end else if (r_reg.aw_addr == ADDR_COMPARE_TWO) begin
        if (r_reg.w_lane) begin
          r_next.compare_value_two = r_reg.w_data;
        end
        clr[F_CMP_TWO] = r_reg.armed[F_CMP_TWO];
      end else if (r_reg.aw_addr == ADDR_CAPTURE_ONE) begin
        clr[F_CAP_ONE] = r_reg.armed[F_CAP_ONE];
      end else if (r_reg.aw_addr == ADDR_CAPTURE_TWO) begin
        clr[F_CAP_TWO] = r_reg.armed[F_CAP_TWO];
      end else if (r_reg.aw_addr == ADDR_COUNTER) begin
        count_write = 1'b1;
      end else if (r_reg.aw_addr != ADDR_TIMER_FLAGS) begin
        wr_ok = 1'b0;
      end
      r_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Clearing disarms; sets below win over a clear in the same cycle
    r_next.flags = r_reg.flags & ~clr;
    r_next.armed = r_next.armed & ~clr;

    // Free-running counter with restart on write or trigger
    if (count_write) begin
      r_next.count = COUNTER_START;
    end else if (r_reg.tick) begin
      r_next.count = r_reg.count + 8'h01;
    end

    // Forced levels only outside pulse and modulation modes
    if (do_write & r_reg.w_lane & (r_reg.aw_addr == ADDR_CONTROL_ONE) & ~pulse_mode & ~pwm_mode) begin
      if (r_reg.w_data[C1_FORCE_ONE] & r_reg.control_two[C2_PIN_EN_ONE]) begin
        r_next.pin[0] = r_reg.w_data[C1_AFTER_LVL];
      end
      if (r_reg.w_data[C1_FORCE_TWO] & r_reg.control_two[C2_PIN_EN_TWO]) begin
        r_next.pin[1] = r_reg.w_data[C1_DURING_LVL];
      end
    end

    // Channel one: ordinary compare or pulse end
    if (pulse_mode) begin
      if (match_one) begin
        r_next.pin[0] = r_reg.control_one[C1_AFTER_LVL];
      end
    end else if (match_one & ~pwm_mode) begin
      r_next.flags[F_CMP_ONE] = 1'b1;
      if (r_reg.control_two[C2_PIN_EN_ONE]) begin
        r_next.pin[0] = r_reg.control_one[C1_AFTER_LVL];
      end
    end

    // Channel two: flags in pulse mode, pin only in ordinary mode
    if (match_two & ~pwm_mode) begin
      r_next.flags[F_CMP_TWO] = 1'b1;
      if (r_reg.control_two[C2_PIN_EN_TWO] & ~pulse_mode) begin
        r_next.pin[1] = r_reg.control_one[C1_DURING_LVL];
      end
    end

    // Capture one: trigger in pulse mode, idle under modulation
    if (edge_one & pulse_mode) begin
      r_next.count = COUNTER_START;
      r_next.pin[0] = r_reg.control_one[C1_DURING_LVL];
      r_next.flags[F_CAP_ONE] = 1'b1;
      r_next.capture_value_one = TRIGGER_CAPTURE;
    end else if (edge_one & ~pwm_mode) begin
      r_next.flags[F_CAP_ONE] = 1'b1;
      r_next.capture_value_one = r_reg.count;
    end

    // Capture two works in every mode
    if (edge_two) begin
      r_next.flags[F_CAP_TWO] = 1'b1;
      r_next.capture_value_two = r_reg.count;
    end

    // Pin ownership follows enables, pin two also released in pulse mode; disabled pins fall back to general I/O
    r_next.pin_oe = {r_reg.control_two[C2_PIN_EN_TWO] & ~pulse_mode,
                     r_reg.control_two[C2_PIN_EN_ONE]};

    // Single shared request, held pending while masked
    r_next.irq = ~cpu_irq_mask &
                 ((r_reg.control_one[C1_CMP_IE] & (r_reg.flags[F_CMP_ONE] | r_reg.flags[F_CMP_TWO])) |
                  (r_reg.control_one[C1_CAP_IE] & (r_reg.flags[F_CAP_ONE] | r_reg.flags[F_CAP_TWO])));
  end

  // State register; reset clears compare values and pin latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.control_one <= CONTROL_RESET;
      r_reg.control_two <= CONTROL_RESET;
      r_reg.compare_value_one <= COMPARE_RESET;
      r_reg.compare_value_two <= COMPARE_RESET;
      r_reg.count <= COUNTER_START;
      r_reg.pin <= 2'h0;
      r_reg.awready <= 1'b1;
      r_reg.wready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : tmo_timer

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tmo_pkg::*;
  logic aclk, aresetn, cpu_irq_mask, tog_one, tog_two, timer_irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic capture_input_one, capture_input_two, compare_output_pin_one, compare_output_pin_one_oe;
  logic compare_output_pin_two, compare_output_pin_two_oe;
  int err_total, samples_checked, cyc, n;

  tmo_timer #(.SLOW_DIV(10)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cpu_irq_mask, .capture_input_one, .capture_input_two, .compare_output_pin_one,
    .compare_output_pin_one_oe, .compare_output_pin_two, .compare_output_pin_two_oe, .timer_irq);
  tmo_pin_model pins (.aclk, .tog_one, .tog_two, .capture_input_one, .capture_input_two);

  // 100 MHz clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard, well above the roughly 450 cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The unmapped offsets used here all lie above the counter, so the expected response follows from the address
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit aw, w;
    @(posedge aclk);
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'h0;
      if (s_axi_wready) w = 1'h0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, (a > ADDR_COUNTER) ? RESP_SLVERR : RESP_OKAY});
  endtask : wr

  // Read; ck selects whether the data is compared
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit ck);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h0;
    chk({30'h0, s_axi_rresp}, {30'h0, (a > ADDR_COUNTER) ? RESP_SLVERR : RESP_OKAY});
    if (ck) chk(rv, e);
  endtask : rd

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {cpu_irq_mask, tog_one, tog_two, aresetn} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    chk({compare_output_pin_one, compare_output_pin_two, timer_irq}, 32'h0);
    rd(ADDR_COMPARE_ONE, 32'h00, 1'h1);
    rd(ADDR_COMPARE_TWO, 32'h00, 1'h1);
    rd(8'h20, 32'h0, 1'h0);
    wr(8'h24, 8'h5A);
    // Channel one match at fast clock; channel two pin disabled but compare two still matches 00
    wr(ADDR_CONTROL_TWO, 8'h01);
    wr(ADDR_CONTROL_ONE, 8'h21);
    wr(ADDR_COMPARE_ONE, 8'h10);
    wr(ADDR_COUNTER, 8'h00);
    for (n = 0; n < 200 && compare_output_pin_one !== 1'h1; n++) @(posedge aclk);
    chk({compare_output_pin_one, compare_output_pin_one_oe}, 32'h3);
    chk({compare_output_pin_two, compare_output_pin_two_oe}, 32'h0);
    rd(ADDR_TIMER_FLAGS, 32'h03, 1'h1);
    chk(timer_irq, 32'h1);
    cpu_irq_mask <= 1'h1;
    repeat (2) @(posedge aclk);
    chk(timer_irq, 32'h0);
    rd(ADDR_COMPARE_ONE, 32'h10, 1'h1);
    rd(ADDR_COMPARE_TWO, 32'h00, 1'h1);
    rd(ADDR_TIMER_FLAGS, 32'h00, 1'h1);
    cpu_irq_mask <= 1'h0;
    // Force level zero onto pin one: no flag may appear
    wr(ADDR_CONTROL_ONE, 8'h04);
    repeat (3) @(posedge aclk);
    chk(compare_output_pin_one, 32'h0);
    rd(ADDR_TIMER_FLAGS, 32'h00, 1'h1);
    chk(timer_irq, 32'h0);
    // Slow clock: pin two rises while the counter holds compare value plus one
    wr(ADDR_CONTROL_TWO, 8'h0E);
    wr(ADDR_CONTROL_ONE, 8'h02);
    wr(ADDR_COMPARE_TWO, 8'h05);
    wr(ADDR_COUNTER, 8'h00);
    for (n = 0; n < 300 && compare_output_pin_two !== 1'h1; n++) @(posedge aclk);
    chk({compare_output_pin_two, compare_output_pin_two_oe, compare_output_pin_one_oe}, 32'h6);
    rd(ADDR_COUNTER, 32'h06, 1'h1);
    rd(ADDR_TIMER_FLAGS, 32'h0, 1'h0);
    rd(ADDR_COMPARE_TWO, 32'h05, 1'h1);
    // Single pulse at divide by four, both pins enabled: rising trigger, during level 1, after level 0
    wr(ADDR_CONTROL_TWO, 8'h17);
    wr(ADDR_CONTROL_ONE, 8'h52);
    wr(ADDR_COMPARE_ONE, 8'h20);
    tog_one <= 1'h1;
    @(posedge aclk);
    tog_one <= 1'h0;
    for (n = 0; n < 20 && compare_output_pin_one !== 1'h1; n++) @(posedge aclk);
    chk(compare_output_pin_one, 32'h1);
    chk(compare_output_pin_two_oe, 32'h0);
    @(posedge aclk); // Request follows the capture flag one clock later
    chk(timer_irq, 32'h1);
    rd(ADDR_CAPTURE_ONE, {24'h0, TRIGGER_CAPTURE}, 1'h1);
    for (n = 0; n < 200 && compare_output_pin_one !== 1'h0; n++) @(posedge aclk);
    chk(compare_output_pin_one, 32'h0);
    rd(ADDR_TIMER_FLAGS, 32'h06, 1'h1);
    rd(ADDR_CAPTURE_ONE, {24'h0, TRIGGER_CAPTURE}, 1'h1);
    rd(ADDR_TIMER_FLAGS, 32'h02, 1'h1);
    // Force with level 1 must be ignored while single pulse is on
    wr(ADDR_CONTROL_ONE, 8'h55);
    repeat (3) @(posedge aclk);
    chk(compare_output_pin_one, 32'h0);
    // Capture two still flags in single pulse mode, rising edge selected
    wr(ADDR_CONTROL_TWO, 8'h57);
    tog_two <= 1'h1;
    @(posedge aclk);
    tog_two <= 1'h0;
    repeat (8) @(posedge aclk);
    rd(ADDR_TIMER_FLAGS, 32'h0A, 1'h1);
    // Modulation bit wins: a falling then rising trigger must not set capture flag one
    wr(ADDR_CONTROL_TWO, 8'h77);
    repeat (2) begin
      tog_one <= 1'h1;
      @(posedge aclk);
      tog_one <= 1'h0;
      repeat (6) @(posedge aclk);
    end
    rd(ADDR_TIMER_FLAGS, 32'h0A, 1'h1);
    stop_test();
  end
endmodule : testbench

// *** verif/tmo_pin_model.sv ***
`timescale 1ns/1ps
module tmo_pin_model (
  input wire logic aclk,
  input wire logic tog_one,
  input wire logic tog_two,
  output logic capture_input_one,
  output logic capture_input_two
);
  // Pins start low, so the first request on pin one gives a rising edge
  initial begin
    capture_input_one = 1'h0;
    capture_input_two = 1'h0;
  end
  // One request flips a pin once and then holds it, long enough for the input synchroniser
  always @(posedge aclk) begin
    if (tog_one) capture_input_one <= ~capture_input_one;
    if (tog_two) capture_input_two <= ~capture_input_two;
  end
endmodule : tmo_pin_model

// *** verif/tmo_timer_props.sv ***
`timescale 1ns/1ps
module tmo_timer_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_irq_mask,
  input wire logic compare_output_pin_one,
  input wire logic compare_output_pin_two,
  input wire logic timer_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset check has to run while reset is low, so it overrides the default disable
  pin_reset_low_a: assert property (disable iff (1'h0) !aresetn |=>
    !compare_output_pin_one && !compare_output_pin_two && !timer_irq) else $error("pins not low in reset");
  irq_masked_a: assert property (cpu_irq_mask |=> !timer_irq) else $error("irq while masked");
  irq_needs_unmask_a: assert property (timer_irq |-> !$past(cpu_irq_mask)) else $error("irq source masked");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_accept_pulse_a: assert property (s_axi_arready |-> s_axi_rvalid ##1 !s_axi_arready)
    else $error("read accept not a pulse");
  write_busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  write_done_c: cover property (s_axi_bvalid && s_axi_bready);
  read_done_c: cover property (s_axi_rvalid && s_axi_rready);
  irq_seen_c: cover property ($rose(timer_irq));
  pin_rise_c: cover property ($rose(compare_output_pin_one));
endmodule : tmo_timer_props

bind tmo_timer tmo_timer_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .cpu_irq_mask, .compare_output_pin_one, .compare_output_pin_two, .timer_irq);
